// ### pmx_pkg.sv
/*
  Package for the decoder / SPI clock pin multiplexer: pad indices,
  function select encodings, and reset values of the control registers.
  Assumes a single 40 MHz clock and synchronous active-high reset.
*/
package pmx_pkg;

  // Number of port C pads handled and their first bit position
  localparam int NUM_C_PADS = 4;
  localparam int PORT_C_BASE_BIT = 4;
  localparam int PORT_E_CLK_BIT = 4;

  // Function chosen for a port C pad
  typedef enum logic [1:0] {
    PMX_FN_DECODER,
    PMX_FN_TIMER,
    PMX_FN_GPIO
  } pmx_fn_t;

  // Reset values: pull-ups on, GPIO direction input, peripheral selected
  localparam logic [3:0] C_PULLUP_RST = 4'hf;
  localparam logic E_PULLUP_RST = 1'b1;
  localparam logic [3:0] C_GPIO_DIR_RST = 4'h0;
  localparam logic [3:0] C_GPIO_OUT_RST = 4'h0;
  localparam logic E_GPIO_DIR_RST = 1'b0;
  localparam logic E_GPIO_OUT_RST = 1'b0;
  localparam logic [7:0] C_FN_SEL_RST = 8'h00;
  localparam logic E_GPIO_SEL_RST = 1'b0;

endpackage : pmx_pkg

// ### pmx_pad_cell.sv
/*
  One multiplexed pad slice: registers the output value, output enable
  and pull-up enable for a pad from the selected function.
  Assumes inputs are already on the clk domain.
*/
`timescale 1ns/1ps
module pmx_pad_cell
(
  input wire logic clk,
  input wire logic rst,
  input wire logic periph_out,
  input wire logic periph_oe,
  input wire logic gpio_sel,
  input wire logic gpio_out,
  input wire logic gpio_dir,
  input wire logic pullup_en,
  output logic pad_out_r,
  output logic pad_oe_r,
  output logic pad_pullup_r
);

  logic pad_out_nxt;
  logic pad_oe_nxt;
  logic pad_pullup_nxt;

  // Choose between peripheral and GPIO drive
  always_comb
  begin
    if (gpio_sel)
    begin
      pad_out_nxt = gpio_out;
      pad_oe_nxt = gpio_dir;
    end
    else
    begin
      pad_out_nxt = periph_out;
      pad_oe_nxt = periph_oe;
    end
    // Pull-up is released while the pad drives, avoiding a fight
    pad_pullup_nxt = pullup_en & ~pad_oe_nxt;
  end

  // Pad registers; reset leaves pad as pulled-up input
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pad_out_r <= 1'b0;
      pad_oe_r <= 1'b0;
      pad_pullup_r <= 1'b1;
    end
    else
    begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
      pad_pullup_r <= pad_pullup_nxt;
    end
  end

endmodule : pmx_pad_cell

// ### pmx_pin_mux.sv
/*
  Pin multiplexer for four port C pads (decoder phase A, phase B, index,
  home / timer A channels 0-3 / GPIO) and the port E SPI clock pad.
  Control bits arrive as plain ports written by software on clk.
  Pad inputs come from pins and are synchronised with two flip-flops.
*/
`timescale 1ns/1ps
module pmx_pin_mux
(
  input wire logic clk,
  input wire logic rst,
  // Software control, same clock domain
  input wire logic ctrl_we,
  input wire logic [7:0] c_fn_sel_wdata,
  input wire logic [3:0] c_gpio_dir_wdata,
  input wire logic [3:0] c_gpio_out_wdata,
  input wire logic [3:0] port_c_pullup_ctrl_wdata,
  input wire logic e_gpio_sel_wdata,
  input wire logic e_gpio_dir_wdata,
  input wire logic e_gpio_out_wdata,
  input wire logic port_e_pullup_ctrl_wdata,
  // Timer A channel drive, channels 0-3
  input wire logic [3:0] timer_a_out,
  input wire logic [3:0] timer_a_oe,
  // SPI side
  input wire logic spi_master_mode,
  input wire logic spi_clk_out,
  // Pad inputs from pins
  input wire logic [3:0] c_pad_in,
  input wire logic e_pad_in,
  // Pad drive
  output logic [3:0] c_pad_out,
  output logic [3:0] c_pad_oe,
  output logic [3:0] c_pad_pullup,
  output logic e_pad_out,
  output logic e_pad_oe,
  output logic e_pad_pullup,
  // Peripheral inputs
  output logic decoder_phase_a_in,
  output logic decoder_phase_b_in,
  output logic decoder_index_in,
  output logic decoder_home_in,
  output logic [3:0] timer_a_in,
  output logic spi_serial_clock_pad,
  // Readback
  output logic [3:0] port_c_gpio_in,
  output logic port_e_gpio_in,
  output logic [7:0] c_fn_sel_rd,
  output logic [3:0] port_c_pullup_ctrl,
  output logic port_e_pullup_ctrl
);

  // Control registers
  logic [7:0] c_fn_sel_r;
  logic [7:0] c_fn_sel_nxt;
  logic [3:0] c_gpio_dir_r;
  logic [3:0] c_gpio_dir_nxt;
  logic [3:0] c_gpio_out_r;
  logic [3:0] c_gpio_out_nxt;
  logic [3:0] c_pullup_r;
  logic [3:0] c_pullup_nxt;
  logic e_gpio_sel_r;
  logic e_gpio_sel_nxt;
  logic e_gpio_dir_r;
  logic e_gpio_dir_nxt;
  logic e_gpio_out_r;
  logic e_gpio_out_nxt;
  logic e_pullup_r;
  logic e_pullup_nxt;

  // Synchronisers and routed inputs
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [3:0] dec_in_r;
  logic [3:0] dec_in_nxt;
  logic [3:0] tmr_in_r;
  logic [3:0] tmr_in_nxt;
  logic spi_clk_in_r;
  logic spi_clk_in_nxt;
  logic [3:0] c_gpio_in_r;
  logic e_gpio_in_r;

  // Per-pad peripheral drive for port C
  logic [3:0] c_periph_out;
  logic [3:0] c_periph_oe;
  logic [3:0] c_is_gpio;

  // Decode a pad's two-bit function field
  function automatic pmx_pkg::pmx_fn_t pad_fn(input logic [7:0] sel,
                                              input int idx);
    logic [1:0] f;
    f = sel[2*idx +: 2];
    case (f)
      2'h1: pad_fn = pmx_pkg::PMX_FN_TIMER;
      2'h2: pad_fn = pmx_pkg::PMX_FN_GPIO;
      default: pad_fn = pmx_pkg::PMX_FN_DECODER;
    endcase
  endfunction : pad_fn

  // Next values of the control registers
  always_comb
  begin
    c_fn_sel_nxt = c_fn_sel_r;
    c_gpio_dir_nxt = c_gpio_dir_r;
    c_gpio_out_nxt = c_gpio_out_r;
    c_pullup_nxt = c_pullup_r;
    e_gpio_sel_nxt = e_gpio_sel_r;
    e_gpio_dir_nxt = e_gpio_dir_r;
    e_gpio_out_nxt = e_gpio_out_r;
    e_pullup_nxt = e_pullup_r;
    if (ctrl_we)
    begin
      c_fn_sel_nxt = c_fn_sel_wdata;
      e_gpio_sel_nxt = e_gpio_sel_wdata;
      c_gpio_dir_nxt = c_gpio_dir_wdata;
      e_gpio_dir_nxt = e_gpio_dir_wdata;
      c_gpio_out_nxt = c_gpio_out_wdata;
      e_gpio_out_nxt = e_gpio_out_wdata;
      c_pullup_nxt = port_c_pullup_ctrl_wdata;
      e_pullup_nxt = port_e_pullup_ctrl_wdata;
    end
  end

  // Control registers; reset selects decoder and SPI clock, pull-ups on
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      c_fn_sel_r <= pmx_pkg::C_FN_SEL_RST;
      e_gpio_sel_r <= pmx_pkg::E_GPIO_SEL_RST;
      c_gpio_dir_r <= pmx_pkg::C_GPIO_DIR_RST;
      c_gpio_out_r <= pmx_pkg::C_GPIO_OUT_RST;
      c_pullup_r <= pmx_pkg::C_PULLUP_RST;
      e_pullup_r <= pmx_pkg::E_PULLUP_RST;
      e_gpio_dir_r <= pmx_pkg::E_GPIO_DIR_RST;
      e_gpio_out_r <= pmx_pkg::E_GPIO_OUT_RST;
    end
    else
    begin
      c_fn_sel_r <= c_fn_sel_nxt;
      e_gpio_sel_r <= e_gpio_sel_nxt;
      c_gpio_dir_r <= c_gpio_dir_nxt;
      c_gpio_out_r <= c_gpio_out_nxt;
      c_pullup_r <= c_pullup_nxt;
      e_pullup_r <= e_pullup_nxt;
      e_gpio_dir_r <= e_gpio_dir_nxt;
      e_gpio_out_r <= e_gpio_out_nxt;
    end
  end

  // Pins are asynchronous: two flops before any logic looks at them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end
    else
    begin
      sync1_r <= {e_pad_in, c_pad_in};
      sync2_r <= sync1_r;
    end
  end

  // Peripheral drive per port C pad; decoder inputs never drive
  always_comb
  begin
    for (int i = 0; i < pmx_pkg::NUM_C_PADS; i++)
    begin
      // Timer A channel i on pad i
      c_periph_out[i] = timer_a_out[i];
      c_periph_oe[i] = 1'b0;
      c_is_gpio[i] = 1'b0;
      case (pad_fn(c_fn_sel_r, i))
        pmx_pkg::PMX_FN_TIMER: c_periph_oe[i] = timer_a_oe[i];
        pmx_pkg::PMX_FN_GPIO: c_is_gpio[i] = 1'b1;
        default: c_periph_oe[i] = 1'b0;
      endcase
    end
  end

  // Route synchronised pad levels to the selected function only
  always_comb
  begin
    dec_in_nxt = dec_in_r;
    tmr_in_nxt = tmr_in_r;
    for (int i = 0; i < pmx_pkg::NUM_C_PADS; i++)
    begin
      case (pad_fn(c_fn_sel_r, i))
        pmx_pkg::PMX_FN_DECODER: dec_in_nxt[i] = sync2_r[i];
        pmx_pkg::PMX_FN_TIMER: tmr_in_nxt[i] = sync2_r[i];
        default: dec_in_nxt[i] = dec_in_r[i];
      endcase
    end
    // Holds last level while in GPIO, so the SPI sees no false edges
    spi_clk_in_nxt = e_gpio_sel_r ? spi_clk_in_r : sync2_r[4];
  end

  // Routed input registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dec_in_r <= 4'h0;
      tmr_in_r <= 4'h0;
      spi_clk_in_r <= 1'b0;
      c_gpio_in_r <= 4'h0;
      e_gpio_in_r <= 1'b0;
    end
    else
    begin
      dec_in_r <= dec_in_nxt;
      tmr_in_r <= tmr_in_nxt;
      spi_clk_in_r <= spi_clk_in_nxt;
      c_gpio_in_r <= sync2_r[3:0];
      e_gpio_in_r <= sync2_r[4];
    end
  end

  // Port C pad slices
  for (genvar g = 0; g < pmx_pkg::NUM_C_PADS; g++)
  begin : g_c_pad
    pmx_pad_cell u_cell
    (
      .clk(clk),
      .rst(rst),
      .periph_out(c_periph_out[g]),
      .periph_oe(c_periph_oe[g]),
      .gpio_sel(c_is_gpio[g]),
      .gpio_out(c_gpio_out_r[g]),
      .gpio_dir(c_gpio_dir_r[g]),
      .pullup_en(c_pullup_r[g]),
      .pad_out_r(c_pad_out[g]),
      .pad_oe_r(c_pad_oe[g]),
      .pad_pullup_r(c_pad_pullup[g])
    );
  end

  // SPI clock pad slice
  // Master drives, slave listens
  pmx_pad_cell u_e_cell
  (
    .clk(clk),
    .rst(rst),
    .periph_out(spi_clk_out),
    .periph_oe(spi_master_mode),
    .gpio_sel(e_gpio_sel_r),
    .gpio_out(e_gpio_out_r),
    .gpio_dir(e_gpio_dir_r),
    .pullup_en(e_pullup_r),
    .pad_out_r(e_pad_out),
    .pad_oe_r(e_pad_oe),
    .pad_pullup_r(e_pad_pullup)
  );

  // Outputs straight from flops
  assign decoder_phase_a_in = dec_in_r[0];
  assign decoder_phase_b_in = dec_in_r[1];
  assign decoder_index_in = dec_in_r[2];
  assign decoder_home_in = dec_in_r[3];
  assign timer_a_in = tmr_in_r;
  assign spi_serial_clock_pad = spi_clk_in_r;
  assign port_c_gpio_in = c_gpio_in_r;
  assign port_e_gpio_in = e_gpio_in_r;
  assign c_fn_sel_rd = c_fn_sel_r;
  assign port_c_pullup_ctrl = c_pullup_r;
  assign port_e_pullup_ctrl = e_pullup_r;

endmodule : pmx_pin_mux

// ### pmx_mux_monitor.sv
/*
  Checker for the pin mux top-level ports.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module pmx_mux_monitor
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrl_we,
  input wire logic [7:0] c_fn_sel_wdata,
  input wire logic [3:0] c_gpio_dir_wdata,
  input wire logic [3:0] c_gpio_out_wdata,
  input wire logic [3:0] port_c_pullup_ctrl_wdata,
  input wire logic e_gpio_sel_wdata,
  input wire logic [3:0] timer_a_out,
  input wire logic [3:0] timer_a_oe,
  input wire logic spi_master_mode,
  input wire logic spi_clk_out,
  input wire logic [3:0] c_pad_out,
  input wire logic [3:0] c_pad_oe,
  input wire logic [3:0] c_pad_pullup,
  input wire logic e_pad_out,
  input wire logic e_pad_oe,
  input wire logic e_pad_pullup,
  input wire logic [7:0] c_fn_sel_rd,
  input wire logic [3:0] port_c_pullup_ctrl,
  input wire logic port_e_pullup_ctrl
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  // A write, then quiet edges while the pad registers catch up
  sequence s_gpio_wr;
    ctrl_we && c_fn_sel_wdata == 8'haa ##1 !ctrl_we;
  endsequence
  sequence s_tmr_wr;
    ctrl_we && c_fn_sel_wdata == 8'h55 ##1 !ctrl_we;
  endsequence
  sequence s_spi_wr;
    ctrl_we && !e_gpio_sel_wdata ##1 !ctrl_we [*2];
  endsequence

  a_reset_state: assert property (
    $fell(rst) |-> c_fn_sel_rd == 8'h00 && port_c_pullup_ctrl == 4'hf
      && port_e_pullup_ctrl && c_pad_pullup == 4'hf && !e_pad_oe)
    else $error("reset state wrong");
  a_ctrl_load: assert property (
    ctrl_we |=> c_fn_sel_rd == $past(c_fn_sel_wdata)
      && port_c_pullup_ctrl == $past(port_c_pullup_ctrl_wdata))
    else $error("control write lost");
  a_c_pull_off: assert property (
    c_pad_pullup == ($past(port_c_pullup_ctrl) & ~c_pad_oe))
    else $error("port c pull-up wrong");
  a_e_pull_off: assert property (
    e_pad_pullup == ($past(port_e_pullup_ctrl) && !e_pad_oe))
    else $error("port e pull-up wrong");
  a_gpio_drive: assert property (
    s_gpio_wr |=> c_pad_oe == $past(c_gpio_dir_wdata, 2)
      && (c_pad_out & c_pad_oe) == ($past(c_gpio_out_wdata, 2) & c_pad_oe))
    else $error("gpio drive wrong");
  a_timer_drive: assert property (
    s_tmr_wr |=> c_pad_oe == $past(timer_a_oe)
      && (c_pad_out & c_pad_oe) == ($past(timer_a_out) & c_pad_oe))
    else $error("timer drive wrong");
  a_spi_dir: assert property (
    s_spi_wr |-> e_pad_oe == $past(spi_master_mode))
    else $error("spi clock direction wrong");
  a_spi_clk: assert property (
    s_spi_wr ##0 $past(spi_master_mode) |-> e_pad_out == $past(spi_clk_out))
    else $error("spi clock drive wrong");
endmodule : pmx_mux_monitor

bind pmx_pin_mux pmx_mux_monitor u_mon
(
  .clk, .rst, .ctrl_we, .c_fn_sel_wdata, .c_gpio_dir_wdata,
  .c_gpio_out_wdata, .port_c_pullup_ctrl_wdata, .e_gpio_sel_wdata,
  .timer_a_out, .timer_a_oe, .spi_master_mode, .spi_clk_out, .c_pad_out,
  .c_pad_oe, .c_pad_pullup, .e_pad_out, .e_pad_oe, .e_pad_pullup,
  .c_fn_sel_rd, .port_c_pullup_ctrl, .port_e_pullup_ctrl
);

// ### pmx_far_model.sv
/*
  Far side of the five pads: encoder lines and the SPI peer.
  Assumes the mux drive ports and a level chosen by the bench.
*/
`timescale 1ns/1ps
module pmx_far_model
(
  input wire logic [4:0] oe,
  input wire logic [4:0] dout,
  input wire logic [4:0] ext_lvl,
  output logic [4:0] wire_lvl
);
  // Peer clocks the pad only while the mux leaves it
  always_comb
  begin
    wire_lvl = (oe & dout) | (~oe & ext_lvl); // Mux wins a clash
  end
endmodule : pmx_far_model

// ### tb_pmx_pin_mux.sv
/*
  Bench for the pin mux; inputs change at the falling edge.
  Assumes the far-side model and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb_pmx_pin_mux;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ctrl_we = 1'b0;
  logic [7:0] c_fn_sel_wdata = 8'h00;
  logic [3:0] c_gpio_dir_wdata = 4'h0;
  logic [3:0] c_gpio_out_wdata = 4'h0;
  logic [3:0] port_c_pullup_ctrl_wdata = 4'hf;
  logic e_gpio_sel_wdata = 1'b0;
  logic e_gpio_dir_wdata = 1'b0;
  logic e_gpio_out_wdata = 1'b0;
  logic port_e_pullup_ctrl_wdata = 1'b1;
  logic [3:0] timer_a_out = 4'h0;
  logic [3:0] timer_a_oe = 4'h0;
  logic spi_master_mode = 1'b0;
  logic spi_clk_out = 1'b0;
  logic [4:0] ext_lvl = 5'h00;
  logic [4:0] lvl;
  logic [3:0] c_pad_out, c_pad_oe, c_pad_pullup, timer_a_in, dec;
  logic [3:0] port_c_gpio_in, port_c_pullup_ctrl;
  logic [7:0] c_fn_sel_rd;
  logic e_pad_out, e_pad_oe, e_pad_pullup, spi_serial_clock_pad;
  logic decoder_phase_a_in, decoder_phase_b_in, decoder_index_in;
  logic decoder_home_in, port_e_gpio_in, port_e_pullup_ctrl;
  int err_total = 0;
  int n_compared = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;
  assign dec = {decoder_home_in, decoder_index_in, decoder_phase_b_in,
    decoder_phase_a_in};

  pmx_pin_mux dut
  (
    .clk, .rst, .ctrl_we, .c_fn_sel_wdata, .c_gpio_dir_wdata,
    .c_gpio_out_wdata, .port_c_pullup_ctrl_wdata, .e_gpio_sel_wdata,
    .e_gpio_dir_wdata, .e_gpio_out_wdata, .port_e_pullup_ctrl_wdata,
    .timer_a_out, .timer_a_oe, .spi_master_mode, .spi_clk_out,
    .c_pad_in(lvl[3:0]), .e_pad_in(lvl[4]), .c_pad_out, .c_pad_oe,
    .c_pad_pullup, .e_pad_out, .e_pad_oe, .e_pad_pullup,
    .decoder_phase_a_in, .decoder_phase_b_in, .decoder_index_in,
    .decoder_home_in, .timer_a_in, .spi_serial_clock_pad,
    .port_c_gpio_in, .port_e_gpio_in, .c_fn_sel_rd,
    .port_c_pullup_ctrl, .port_e_pullup_ctrl
  );

  pmx_far_model far
  (
    .oe({e_pad_oe, c_pad_oe}), .dout({e_pad_out, c_pad_out}),
    .ext_lvl, .wire_lvl(lvl)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // Pulse the write strobe; returns once the pad registers follow
  task automatic wr;
    @(negedge clk);
    ctrl_we = 1'b1;
    @(negedge clk);
    ctrl_we = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic t_route;
    chk(c_fn_sel_rd, 8'h00);
    chk({e_pad_pullup, c_pad_pullup}, 8'h1f);
    for (int k = 0; k < 2; k++)
    begin
      ext_lvl = k ? 5'h0a : 5'h15;
      repeat (4) @(negedge clk);
      chk(dec, ext_lvl[3:0]);
      chk(spi_serial_clock_pad, ext_lvl[4]);
    end
    $display("route test done");
  endtask : t_route

  task automatic t_pull;
    logic [3:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = ~(4'h1 << i);
      port_c_pullup_ctrl_wdata = m;
      wr();
      chk(c_pad_pullup, m);
    end
    port_c_pullup_ctrl_wdata = 4'hf;
    port_e_pullup_ctrl_wdata = 1'b0;
    wr();
    chk({e_pad_pullup, c_pad_pullup}, 8'h0f);
    port_e_pullup_ctrl_wdata = 1'b1;
    $display("pull-up test done");
  endtask : t_pull

  task automatic t_gpio;
    c_fn_sel_wdata = 8'haa;
    c_gpio_dir_wdata = 4'h5;
    c_gpio_out_wdata = 4'hf;
    e_gpio_sel_wdata = 1'b1;
    e_gpio_dir_wdata = 1'b1;
    e_gpio_out_wdata = 1'b1;
    ext_lvl = 5'h00;
    wr();
    chk({e_pad_oe, c_pad_oe}, 8'h15);
    chk(c_pad_out & c_pad_oe, 8'h05);
    repeat (4) @(negedge clk);
    chk(port_c_gpio_in, 8'h05);
    chk(port_e_gpio_in, 8'h01);
    // Decoder inputs keep the last level seen in decoder mode
    chk(dec, 8'h0a);
    c_gpio_dir_wdata = 4'ha;
    wr();
    chk(c_pad_oe, 8'h0a);
    $display("gpio test done");
  endtask : t_gpio

  task automatic t_timer;
    c_fn_sel_wdata = 8'h55;
    timer_a_oe = 4'h3;
    timer_a_out = 4'h1;
    ext_lvl = 5'h08;
    wr();
    chk(c_pad_out & c_pad_oe, 8'h01);
    repeat (4) @(negedge clk);
    chk(timer_a_in, 8'h09);
    $display("timer test done");
  endtask : t_timer

  // Mid-run reset must undo a changed configuration
  task automatic t_reset;
    port_c_pullup_ctrl_wdata = 4'h0;
    port_e_pullup_ctrl_wdata = 1'b0;
    wr();
    chk({port_e_pullup_ctrl, port_c_pullup_ctrl}, 8'h00);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    port_c_pullup_ctrl_wdata = 4'hf;
    port_e_pullup_ctrl_wdata = 1'b1;
    @(negedge clk);
    chk(c_fn_sel_rd, 8'h00);
    chk({e_pad_oe, c_pad_oe}, 8'h00);
    chk({port_e_pullup_ctrl, port_c_pullup_ctrl}, 8'h1f);
    chk({e_pad_pullup, c_pad_pullup}, 8'h1f);
    $display("reset test done");
  endtask : t_reset

  task automatic t_spi;
    // Code 3 in every pad field must still mean decoder
    c_fn_sel_wdata = 8'hff;
    e_gpio_sel_wdata = 1'b0;
    spi_master_mode = 1'b1;
    wr();
    chk(e_pad_oe, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      spi_clk_out = ~spi_clk_out;
      @(negedge clk);
      chk(e_pad_out, spi_clk_out);
    end
    spi_master_mode = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      // Peer supplies the clock while the pad listens
      ext_lvl = k ? 5'h0a : 5'h15;
      repeat (4) @(negedge clk);
      chk(e_pad_oe, 8'h00);
      chk(spi_serial_clock_pad, ext_lvl[4]);
      chk(dec, ext_lvl[3:0]);
    end
    $display("spi test done");
  endtask : t_spi

  // Main sequence after 16 cycles of reset
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_route();
    t_pull();
    t_gpio();
    t_timer();
    t_reset();
    t_spi();
    end_of_test();
  end

  // Watchdog: the tests need well under 200 cycles
  initial
  begin
    #(2000 * 25);
    err_total++;
    end_of_test();
  end
endmodule : tb_pmx_pin_mux
